// ==== hw/dbc_top.sv ====
// Purpose: Data buffer FIFO and DMA tracker control registers
// Assumes: Configuration port is synchronous, one access per cycle
// Notes:   Strobes act in the cycle after the write and read as zero
//
// Summary of operation
// - Writing one to memory-leak flush empties all outbound FIFOs.
// - Per-link one pulses outbound encoder-side queue counter clear.
// - Per-link one pulses outbound bus-side queue counter clear.
// - Per-link one pulses inbound bus-side queue counter clear.
// - Tracker error inputs also clear queue and depth counters.
// - Per-link one pulses outbound DMA depth counter clear.
// - Per-link one pulses inbound DMA depth counter clear.
// - Disabled channel stays flushed; its writes rejected, no address error.
// - Enabled channel accepts bus writes into its FIFO.
// - Per-channel flush bit pulses pointer reset, FIFO stays enabled.
// - Rate value n gives one partial event per n+1 writes.
// - Any partition write clears inbound FIFOs, applies new boundaries.
// - Five-bit bases times sixteen; each ends previous FIFO one below.
// - Capture force bit strobes capture event for one cycle.
// - Inbound force bits strobe matching inbound events one cycle.
// - Per-link three-bit start value loads outbound trackers.
// - Per-link bit enables outbound tracker auto resynchronisation.
`timescale 1ns/1ps
`default_nettype none
module dbc_top
  import dbc_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                cfg_wr,
  input  wire logic                cfg_rd,
  input  wire logic [ADDR_W-1:0]   cfg_addr,
  input  wire logic [31:0]         cfg_wdata,
  output logic      [31:0]         cfg_rdata,
  output logic                     cfg_addr_error,
  input  wire logic [LINKS-1:0]    out_tracker_error,
  input  wire logic [LINKS-1:0]    in_tracker_error,
  input  wire logic                out_wr_valid,
  input  wire logic [4:0]          out_wr_channel,
  output logic                     out_wr_accept,
  output logic                     out_wr_reject,
  input  wire logic [IN_FIFOS-1:0] in_fifo_write,
  output logic [LINKS-1:0]         out_encoder_queue_clear,
  output logic [LINKS-1:0]         out_bus_queue_clear,
  output logic [LINKS-1:0]         in_bus_queue_clear,
  output logic [LINKS-1:0]         out_depth_clear,
  output logic [LINKS-1:0]         in_depth_clear,
  output logic [CHANNELS-1:0]      out_fifo_flush,
  output logic [CHANNELS-1:0]      out_fifo_enable_bits,
  output logic                     in_fifo_clear,
  output logic [QADDR_W-1:0]       in_fifo1_start,
  output logic [QADDR_W-1:0]       in_fifo2_start,
  output logic [QADDR_W-1:0]       error_fifo_start,
  output logic [QADDR_W-1:0]       in_fifo0_end,
  output logic [QADDR_W-1:0]       in_fifo1_end,
  output logic [QADDR_W-1:0]       in_fifo2_end,
  output logic                     capture_buffer_nonempty_event,
  output logic [3:0]               inbound_nonempty_event,
  output logic [IN_FIFOS-1:0]      partial_nonempty_event,
  output logic [LINKS*TRK_W-1:0]   out_tracker_start_value,
  output logic [LINKS-1:0]         out_tracker_resync_enable
);
  dbc_rate_if rate_bus ();

  logic                 wr_generic;
  logic                 wr_que_clr;
  logic                 wr_depth_clr;
  logic                 wr_out_en;
  logic                 wr_out_flush;
  logic                 wr_evt_rate;
  logic                 wr_partition;
  logic                 wr_force;
  logic                 wr_autosync;
  logic                 addr_mapped;
  logic [11:0]          evt_rate;
  logic [BASE_W-1:0]    in_fifo1_base;
  logic [BASE_W-1:0]    in_fifo2_base;
  logic [BASE_W-1:0]    error_fifo_base;
  logic [31:0]          autosync;
  logic [QADDR_W-1:0]   next_fifo1_start;
  logic [QADDR_W-1:0]   next_fifo2_start;
  logic [QADDR_W-1:0]   next_error_start;
  logic [LINKS-1:0]     out_enc_strobe;
  logic [LINKS-1:0]     out_bus_strobe;
  logic [LINKS-1:0]     in_bus_strobe;
  logic [LINKS-1:0]     out_depth_strobe;
  logic [LINKS-1:0]     in_depth_strobe;
  logic [CHANNELS-1:0]  flush_strobe;
  logic                 mem_leak_strobe;

  // Address decode
  assign wr_generic   = cfg_wr && (cfg_addr == ADDR_GENERIC);
  assign wr_que_clr   = cfg_wr && (cfg_addr == ADDR_QUE_CLR);
  assign wr_depth_clr = cfg_wr && (cfg_addr == ADDR_DEPTH_CLR);
  assign wr_out_en    = cfg_wr && (cfg_addr == ADDR_OUT_EN);
  assign wr_out_flush = cfg_wr && (cfg_addr == ADDR_OUT_FLUSH);
  assign wr_evt_rate  = cfg_wr && (cfg_addr == ADDR_EVT_RATE);
  assign wr_partition = cfg_wr && (cfg_addr == ADDR_PARTITION);
  assign wr_force     = cfg_wr && (cfg_addr == ADDR_FORCE);
  assign wr_autosync  = cfg_wr && (cfg_addr == ADDR_AUTOSYNC);
  assign addr_mapped  = (cfg_addr <= ADDR_AUTOSYNC);

  // Strobe fields are never stored, only gated by the write
  assign mem_leak_strobe  = wr_generic
                            && cfg_wdata[POS_MEM_LEAK_FLUSH];
  assign out_enc_strobe   = wr_que_clr
                            ? cfg_wdata[POS_OUT_ENC_QUE +: LINKS]
                            : '0;
  assign out_bus_strobe   = wr_que_clr
                            ? cfg_wdata[POS_OUT_BUS_QUE +: LINKS]
                            : '0;
  assign in_bus_strobe    = wr_que_clr
                            ? cfg_wdata[POS_IN_BUS_QUE +: LINKS]
                            : '0;
  assign out_depth_strobe = wr_depth_clr
                            ? cfg_wdata[POS_OUT_DEPTH +: LINKS]
                            : '0;
  assign in_depth_strobe  = wr_depth_clr
                            ? cfg_wdata[POS_IN_DEPTH +: LINKS]
                            : '0;
  assign flush_strobe     = wr_out_flush
                            ? cfg_wdata[CHANNELS-1:0]
                            : '0;

  // Quadword start addresses of the inbound partitions
  assign next_fifo1_start = {cfg_wdata[POS_FIFO1_BASE +: BASE_W],
                             4'h0};
  assign next_fifo2_start = {cfg_wdata[POS_FIFO2_BASE +: BASE_W],
                             4'h0};
  assign next_error_start = {cfg_wdata[POS_ERR_BASE +: BASE_W],
                             4'h0};

  // Queue and depth clear strobes, software or tracker error
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_encoder_queue_clear <= '0;
      out_bus_queue_clear     <= '0;
      in_bus_queue_clear      <= '0;
      out_depth_clear         <= '0;
      in_depth_clear          <= '0;
    end else begin
      out_encoder_queue_clear <= out_enc_strobe
                                 | out_tracker_error;
      out_bus_queue_clear     <= out_bus_strobe
                                 | out_tracker_error;
      in_bus_queue_clear      <= in_bus_strobe
                                 | in_tracker_error;
      out_depth_clear         <= out_depth_strobe
                                 | out_tracker_error;
      in_depth_clear          <= in_depth_strobe
                                 | in_tracker_error;
    end
  end

  // Outbound channel enables
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_fifo_enable_bits <= RST_OUT_EN;
    end else if (wr_out_en) begin
      out_fifo_enable_bits <= cfg_wdata[CHANNELS-1:0];
    end
  end

  // Disabled channels are held in flush; memory leak flushes all
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_fifo_flush <= '1;
    end else begin
      out_fifo_flush <= flush_strobe
                        | ~out_fifo_enable_bits
                        | {CHANNELS{mem_leak_strobe}};
    end
  end

  // Outbound bus writes into channel FIFOs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_wr_accept <= 1'b0;
      out_wr_reject <= 1'b0;
    end else if (out_wr_valid
                 && (out_wr_channel < 5'(CHANNELS))
                 && out_fifo_enable_bits[out_wr_channel]) begin
      out_wr_accept <= 1'b1;
      out_wr_reject <= 1'b0;
    end else begin
      out_wr_accept <= 1'b0;
      out_wr_reject <= out_wr_valid;
    end
  end

  // Inbound event rate settings
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      evt_rate <= RST_EVT_RATE;
    end else if (wr_evt_rate) begin
      evt_rate <= cfg_wdata[11:0];
    end
  end

  // Inbound partition boundaries
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      in_fifo1_base    <= RST_BASE;
      in_fifo2_base    <= RST_BASE;
      error_fifo_base  <= RST_BASE;
      in_fifo1_start   <= '0;
      in_fifo2_start   <= '0;
      error_fifo_start <= '0;
      in_fifo0_end     <= '1;
      in_fifo1_end     <= '1;
      in_fifo2_end     <= '1;
    end else if (wr_partition) begin
      in_fifo1_base    <= cfg_wdata[POS_FIFO1_BASE +: BASE_W];
      in_fifo2_base    <= cfg_wdata[POS_FIFO2_BASE +: BASE_W];
      error_fifo_base  <= cfg_wdata[POS_ERR_BASE +: BASE_W];
      in_fifo1_start   <= next_fifo1_start;
      in_fifo2_start   <= next_fifo2_start;
      error_fifo_start <= next_error_start;
      in_fifo0_end     <= next_fifo1_start - 9'h001;
      in_fifo1_end     <= next_fifo2_start - 9'h001;
      in_fifo2_end     <= next_error_start - 9'h001;
    end
  end

  // Any partition write empties every inbound FIFO
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      in_fifo_clear <= 1'b0;
    end else begin
      in_fifo_clear <= wr_partition;
    end
  end

  // Partial not-empty event spacing
  assign rate_bus.fifo_write = in_fifo_write;
  assign rate_bus.clear      = wr_partition;
  assign rate_bus.depth      = evt_rate;

  dbc_event_rate u_event_rate (
    .clk    (clk),
    .resetn (resetn),
    .rate   (rate_bus)
  );

  // Forced system events
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      capture_buffer_nonempty_event <= 1'b0;
      inbound_nonempty_event        <= '0;
      partial_nonempty_event        <= '0;
    end else begin
      capture_buffer_nonempty_event <= wr_force
                                       && cfg_wdata[POS_FORCE_CAPT];
      inbound_nonempty_event <= wr_force
                                ? cfg_wdata[POS_FORCE_NE +: 4]
                                : 4'h0;
      partial_nonempty_event <= (wr_force
                                 ? cfg_wdata[POS_FORCE_PNE +: IN_FIFOS]
                                 : 3'h0)
                                | rate_bus.event_out;
    end
  end

  // Outbound tracker auto synchronisation
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      autosync <= RST_AUTOSYNC;
    end else if (wr_autosync) begin
      autosync <= cfg_wdata & AUTOSYNC_MASK;
    end
  end

  genvar g;
  generate
    for (g = 0; g < LINKS; g++) begin : g_link
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          out_tracker_start_value[g*TRK_W +: TRK_W] <= '0;
          out_tracker_resync_enable[g]             <= 1'b0;
        end else begin
          out_tracker_start_value[g*TRK_W +: TRK_W]
            <= autosync[POS_TRK_VALUE + g*TRK_STRIDE +: TRK_W];
          out_tracker_resync_enable[g]
            <= autosync[POS_TRK_EN + g];
        end
      end
    end
  endgenerate

  // Read port; write-only registers read as zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_rdata <= '0;
    end else if (cfg_rd) begin
      case (cfg_addr)
        ADDR_OUT_EN: begin
          cfg_rdata <= {2'b00, out_fifo_enable_bits};
        end
        ADDR_EVT_RATE: begin
          cfg_rdata <= {20'h00000, evt_rate};
        end
        ADDR_PARTITION: begin
          cfg_rdata <= {11'h000, error_fifo_base, 3'h0,
                        in_fifo2_base, 3'h0, in_fifo1_base};
        end
        ADDR_AUTOSYNC: begin
          cfg_rdata <= autosync;
        end
        default: begin
          cfg_rdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  // Unmapped index on either access
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_addr_error <= 1'b0;
    end else begin
      cfg_addr_error <= (cfg_wr || cfg_rd) && !addr_mapped;
    end
  end
endmodule
`default_nettype wire

// ==== common/dbc_pkg.sv ====
// Purpose: Shared constants of the data buffer control block
// Assumes: 32-bit configuration word, register index on the address port
// Notes:   Field positions give the low bit of each field
`default_nettype none
package dbc_pkg;
  localparam int unsigned LINKS    = 6;
  localparam int unsigned CHANNELS = 30;
  localparam int unsigned IN_FIFOS = 3;
  localparam int unsigned ADDR_W   = 4;
  localparam int unsigned RATE_W   = 4;
  localparam int unsigned BASE_W   = 5;
  localparam int unsigned QADDR_W  = 9;
  localparam int unsigned TRK_W    = 3;

  // Register indices
  localparam logic [3:0] ADDR_GENERIC   = 4'h0;
  localparam logic [3:0] ADDR_QUE_CLR   = 4'h1;
  localparam logic [3:0] ADDR_DEPTH_CLR = 4'h2;
  localparam logic [3:0] ADDR_OUT_EN    = 4'h3;
  localparam logic [3:0] ADDR_OUT_FLUSH = 4'h4;
  localparam logic [3:0] ADDR_EVT_RATE  = 4'h5;
  localparam logic [3:0] ADDR_PARTITION = 4'h6;
  localparam logic [3:0] ADDR_FORCE     = 4'h7;
  localparam logic [3:0] ADDR_AUTOSYNC  = 4'h8;

  // Field positions
  localparam int unsigned POS_MEM_LEAK_FLUSH = 0;
  localparam int unsigned POS_OUT_ENC_QUE    = 16;
  localparam int unsigned POS_OUT_BUS_QUE    = 8;
  localparam int unsigned POS_IN_BUS_QUE     = 0;
  localparam int unsigned POS_OUT_DEPTH      = 8;
  localparam int unsigned POS_IN_DEPTH       = 0;
  localparam int unsigned POS_FIFO1_BASE     = 0;
  localparam int unsigned POS_FIFO2_BASE     = 8;
  localparam int unsigned POS_ERR_BASE       = 16;
  localparam int unsigned POS_FORCE_CAPT     = 7;
  localparam int unsigned POS_FORCE_NE       = 0;
  localparam int unsigned POS_FORCE_PNE      = 4;
  localparam int unsigned POS_TRK_VALUE      = 8;
  localparam int unsigned TRK_STRIDE         = 4;
  localparam int unsigned POS_TRK_EN         = 0;
  localparam int unsigned QADDR_SHIFT        = 4;

  // Reset values
  localparam logic [29:0] RST_OUT_EN    = 30'h0000_0000;
  localparam logic [11:0] RST_EVT_RATE  = 12'h000;
  localparam logic [4:0]  RST_BASE      = 5'h00;
  localparam logic [31:0] RST_AUTOSYNC  = 32'h0000_0000;
  localparam logic [31:0] AUTOSYNC_MASK = 32'h7777_773F;
endpackage
`default_nettype wire

// ==== common/dbc_rate_if.sv ====
// Purpose: Carrier between control logic and the event rate counters
// Assumes: One clock domain
// Notes:   Event bits are registered in the counter module
`timescale 1ns/1ps
`default_nettype none
interface dbc_rate_if;
  logic [2:0]  fifo_write;
  logic        clear;
  logic [11:0] depth;
  logic [2:0]  event_out;
  modport ctrl (output fifo_write, output clear, output depth,
                input event_out);
  modport rate (input fifo_write, input clear, input depth,
                output event_out);
endinterface
`default_nettype wire

// ==== hw/dbc_event_rate.sv ====
// Purpose: Modulo counters that space out partial not-empty events
// Assumes: Writes arrive as one-cycle pulses per inbound FIFO
// Notes:   Field value n gives one event every n+1 writes
`timescale 1ns/1ps
`default_nettype none
module dbc_event_rate
  import dbc_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  resetn,
  dbc_rate_if.rate   rate
);
  genvar g;
  generate
    for (g = 0; g < IN_FIFOS; g++) begin : g_fifo
      logic [RATE_W-1:0] count;
      logic [RATE_W-1:0] limit;
      assign limit = rate.depth[g*RATE_W +: RATE_W];
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          count             <= '0;
          rate.event_out[g] <= 1'b0;
        end else if (rate.clear) begin
          // Clear wins over a write in the same cycle
          count             <= '0;
          rate.event_out[g] <= 1'b0;
        end else if (rate.fifo_write[g]) begin
          if (count == limit) begin
            count             <= '0;
            rate.event_out[g] <= 1'b1;
          end else begin
            count             <= count + 4'h1;
            rate.event_out[g] <= 1'b0;
          end
        end else begin
          rate.event_out[g] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ==== testbench/dbc_top_monitor.sv ====
// Purpose: Port checker for the data buffer control block
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound to every dbc_top instance
`timescale 1ns/1ps
`default_nettype none
module dbc_top_monitor
  import dbc_pkg::*;
(
  input wire logic                clk,
  input wire logic                resetn,
  input wire logic                cfg_wr,
  input wire logic                cfg_rd,
  input wire logic [ADDR_W-1:0]   cfg_addr,
  input wire logic [31:0]         cfg_wdata,
  input wire logic                cfg_addr_error,
  input wire logic [LINKS-1:0]    out_tracker_error,
  input wire logic [LINKS-1:0]    in_tracker_error,
  input wire logic                out_wr_valid,
  input wire logic [4:0]          out_wr_channel,
  input wire logic                out_wr_accept,
  input wire logic                out_wr_reject,
  input wire logic [LINKS-1:0]    out_encoder_queue_clear,
  input wire logic [LINKS-1:0]    out_bus_queue_clear,
  input wire logic [LINKS-1:0]    in_bus_queue_clear,
  input wire logic [LINKS-1:0]    out_depth_clear,
  input wire logic [LINKS-1:0]    in_depth_clear,
  input wire logic [CHANNELS-1:0] out_fifo_flush,
  input wire logic [CHANNELS-1:0] out_fifo_enable_bits,
  input wire logic                in_fifo_clear,
  input wire logic                capture_buffer_nonempty_event
);
  logic             q_wr, d_wr, p_wr, bad, ch_ok;
  logic [LINKS-1:0] e_enc, e_obq, e_ibq, e_odp, e_idp;

  assign q_wr  = cfg_wr && (cfg_addr == ADDR_QUE_CLR);
  assign d_wr  = cfg_wr && (cfg_addr == ADDR_DEPTH_CLR);
  assign p_wr  = cfg_wr && (cfg_addr == ADDR_PARTITION);
  assign bad   = (cfg_wr || cfg_rd) && (cfg_addr > 4'h8);
  // Index read only when in range
  assign ch_ok = (out_wr_channel < 5'h1E) &&
                 out_fifo_enable_bits[out_wr_channel];
  assign e_enc = (q_wr ? cfg_wdata[21:16] : 6'h00) | out_tracker_error;
  assign e_obq = (q_wr ? cfg_wdata[13:8] : 6'h00) | out_tracker_error;
  assign e_ibq = (q_wr ? cfg_wdata[5:0] : 6'h00) | in_tracker_error;
  assign e_odp = (d_wr ? cfg_wdata[13:8] : 6'h00) | out_tracker_error;
  assign e_idp = (d_wr ? cfg_wdata[5:0] : 6'h00) | in_tracker_error;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_capt_wr;
    cfg_wr && (cfg_addr == ADDR_FORCE) && cfg_wdata[POS_FORCE_CAPT];
  endsequence
  sequence s_one_pulse;
    capture_buffer_nonempty_event ##1 !capture_buffer_nonempty_event;
  endsequence

  chk_enc_queue_clear: assert property (
    out_encoder_queue_clear == $past(e_enc)) else $error("enc clear bad");
  chk_bus_queue_clear: assert property (
    out_bus_queue_clear == $past(e_obq)) else $error("bus clear bad");
  chk_in_queue_clear: assert property (
    in_bus_queue_clear == $past(e_ibq)) else $error("in queue clear bad");
  chk_out_depth_clear: assert property (
    out_depth_clear == $past(e_odp)) else $error("out depth clear bad");
  chk_in_depth_clear: assert property (
    in_depth_clear == $past(e_idp)) else $error("in depth clear bad");
  chk_write_taken: assert property (
    out_wr_valid && ch_ok |=> out_wr_accept && !out_wr_reject)
    else $error("enabled write not accepted");
  chk_write_refused: assert property (
    out_wr_valid && !ch_ok |=> out_wr_reject && !out_wr_accept)
    else $error("disabled write not rejected");
  chk_no_write_answer: assert property (
    !out_wr_valid |=> !out_wr_accept && !out_wr_reject)
    else $error("answer without write");
  chk_off_stays_flushed: assert property (
    &(out_fifo_flush | $past(out_fifo_enable_bits)))
    else $error("disabled channel not flushed");
  chk_partition_clear: assert property (
    in_fifo_clear == $past(p_wr)) else $error("inbound clear bad");
  chk_capture_pulse: assert property (
    s_capt_wr |=> s_one_pulse) else $error("capture event not one cycle");
  chk_addr_error: assert property (
    cfg_addr_error == $past(bad)) else $error("address error bad");
endmodule

bind dbc_top dbc_top_monitor dbc_top_monitor_inst (.*);
`default_nettype wire

// ==== testbench/dbc_dma_model.sv ====
// Purpose: DMA engine and FIFO writers beside the control block
// Assumes: Bench requests are one-cycle pulses
// Notes:   Slow mode leaves a gap cycle between inbound writes
`timescale 1ns/1ps
`default_nettype none
module dbc_dma_model
  import dbc_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                m_start,
  input  wire logic [4:0]          m_burst,
  input  wire logic [IN_FIFOS-1:0] m_mask,
  input  wire logic                m_slow,
  input  wire logic                m_ow_req,
  input  wire logic [4:0]          m_ow_ch,
  output logic                     m_busy,
  output logic                     out_wr_valid,
  output logic [4:0]               out_wr_channel,
  output logic [IN_FIFOS-1:0]      in_fifo_write
);
  logic [4:0] left;
  logic       gap;
  logic       go;

  assign go     = (left != 5'h00) && !(m_slow && gap);
  assign m_busy = left != 5'h00;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      left          <= 5'h00;
      gap           <= 1'b0;
      in_fifo_write <= 3'h0;
    end else begin
      if (m_start)
        left <= m_burst;
      else if (go)
        left <= left - 5'h01;
      gap           <= m_slow && !gap;
      in_fifo_write <= go ? m_mask : 3'h0;
    end
  end

  // Channel lines toggle while idle so a stale value never looks valid
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_wr_valid   <= 1'b0;
      out_wr_channel <= 5'h00;
    end else begin
      out_wr_valid   <= m_ow_req;
      out_wr_channel <= m_ow_req ? m_ow_ch : ~out_wr_channel;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/test_data_buffer_fifo_dma_control.sv ====
// Purpose: Self-checking bench of the data buffer control block
// Assumes: Register port takes one access per request, answers next cycle
// Notes:   Inbound and outbound writes come from the DMA model
`timescale 1ns/1ps
`default_nettype none
module test_data_buffer_fifo_dma_control
  import dbc_pkg::*;
;
  logic clk, resetn, cfg_wr, cfg_rd, cfg_addr_error, in_fifo_clear;
  logic out_wr_valid, out_wr_accept, out_wr_reject;
  logic capture_buffer_nonempty_event, m_start, m_slow, m_ow_req, m_busy;
  logic [ADDR_W-1:0] cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [4:0] out_wr_channel, m_burst, m_ow_ch;
  logic [LINKS-1:0] out_tracker_error, in_tracker_error;
  logic [LINKS-1:0] out_encoder_queue_clear, out_bus_queue_clear;
  logic [LINKS-1:0] in_bus_queue_clear, out_depth_clear, in_depth_clear;
  logic [CHANNELS-1:0] out_fifo_flush, out_fifo_enable_bits;
  logic [QADDR_W-1:0] in_fifo1_start, in_fifo2_start, error_fifo_start;
  logic [QADDR_W-1:0] in_fifo0_end, in_fifo1_end, in_fifo2_end;
  logic [3:0] inbound_nonempty_event;
  logic [2:0] partial_nonempty_event, in_fifo_write, m_mask;
  logic [LINKS*TRK_W-1:0] out_tracker_start_value;
  logic [LINKS-1:0] out_tracker_resync_enable;
  int miscompares, tests_run, cycles;
  int pne_cnt [3];

  dbc_top dbc_top_inst (.*);
  dbc_dma_model dbc_dma_model_inst (.*);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (resetn)
      for (int k = 0; k < 3; k++) pne_cnt[k] += partial_nonempty_event[k];
    if (cycles == 5000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic acc(logic w, logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    cfg_wr    <= w;
    cfg_rd    <= !w;
    cfg_addr  <= a;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
    #1;
  endtask

  task automatic wr(logic [3:0] a, logic [31:0] d);
    acc(1'b1, a, d);
  endtask

  task automatic rd(logic [3:0] a, logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk("rdata", e, cfg_rdata);
  endtask

  task automatic ow(logic [4:0] ch, logic ok);
    @(posedge clk);
    m_ow_req <= 1'b1;
    m_ow_ch  <= ch;
    @(posedge clk);
    m_ow_req <= 1'b0;
    @(posedge clk);
    #1;
    chk("accept", ok, out_wr_accept);
    chk("reject", !ok, out_wr_reject);
    chk("addr_error", 32'h0, cfg_addr_error);
  endtask

  task automatic burst(logic [2:0] mask, logic [4:0] n, logic slow);
    int t;
    t = 0;
    @(posedge clk);
    m_start <= 1'b1;
    m_mask  <= mask;
    m_burst <= n;
    m_slow  <= slow;
    @(posedge clk);
    m_start <= 1'b0;
    #1;
    while (m_busy === 1'b1 && t < 100) begin
      @(posedge clk);
      #1;
      t++;
    end
    repeat (3) @(posedge clk);
    #1;
  endtask

  initial begin
    {resetn, cfg_wr, cfg_rd, m_start, m_slow, m_ow_req} = 6'h00;
    {cfg_addr, cfg_wdata, m_burst, m_ow_ch, m_mask} = '0;
    {out_tracker_error, in_tracker_error} = 12'h000;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    #1;
    chk("flush", 32'h3FFF_FFFF, out_fifo_flush);
    chk("ends", 27'h7FF_FFFF, {in_fifo0_end, in_fifo1_end, in_fifo2_end});
    for (int a = 0; a < 9; a++) rd(a[3:0], 32'h0);
    wr(4'h9, 32'hFFFF_FFFF);
    chk("addr_error", 32'h1, cfg_addr_error);
    rd(4'h9, 32'h0);
    $display("test reset and map done");
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_QUE_CLR, 32'h8001_0000 << i | 32'h2000 >> i | 32'h1 << i);
      chk("enc_clear", 32'h1 << i, out_encoder_queue_clear);
      chk("bus_clear", 32'h20 >> i, out_bus_queue_clear);
      chk("in_bus_clear", 32'h1 << i, in_bus_queue_clear);
      wr(ADDR_DEPTH_CLR, 32'h100 << i | 32'h20 >> i);
      chk("enc_clear", 32'h0, out_encoder_queue_clear);
      chk("out_depth", 32'h1 << i, out_depth_clear);
      chk("in_depth", 32'h20 >> i, in_depth_clear);
    end
    @(posedge clk);
    out_tracker_error <= 6'h21;
    in_tracker_error  <= 6'h12;
    @(posedge clk);
    out_tracker_error <= 6'h00;
    in_tracker_error  <= 6'h00;
    #1;
    chk("auto_out", 32'h21861, {out_encoder_queue_clear,
        out_bus_queue_clear, out_depth_clear});
    chk("auto_in", 32'h492, {in_bus_queue_clear, in_depth_clear});
    $display("test queue and depth clears done");
    wr(ADDR_OUT_EN, 32'hE000_0001);
    rd(ADDR_OUT_EN, 32'h2000_0001);
    chk("flush", 32'h1FFF_FFFE, out_fifo_flush);
    ow(5'd0, 1'b1);
    ow(5'd1, 1'b0);
    ow(5'd29, 1'b1);
    ow(5'd30, 1'b0);
    wr(ADDR_OUT_FLUSH, 32'h2000_0000);
    chk("flush", 32'h3FFF_FFFE, out_fifo_flush);
    chk("enable", 32'h2000_0001, out_fifo_enable_bits);
    rd(ADDR_OUT_FLUSH, 32'h0);
    wr(ADDR_GENERIC, 32'h0);
    chk("flush", 32'h1FFF_FFFE, out_fifo_flush);
    wr(ADDR_GENERIC, 32'h1);
    chk("flush", 32'h3FFF_FFFF, out_fifo_flush);
    ow(5'd29, 1'b1);
    $display("test outbound fifos done");
    wr(ADDR_EVT_RATE, 32'hFFFF_0F20);
    rd(ADDR_EVT_RATE, 32'h0000_0F20);
    pne_cnt = '{0, 0, 0};
    burst(3'h7, 5'd16, 1'b0);
    chk("pne0", 32'd16, pne_cnt[0]);
    chk("pne1", 32'd5, pne_cnt[1]);
    chk("pne2", 32'd1, pne_cnt[2]);
    wr(ADDR_PARTITION, 32'hFFFF_EA05);
    chk("in_clear", 32'h1, in_fifo_clear);
    rd(ADDR_PARTITION, 32'h001F_0A05);
    chk("starts", {9'h050, 9'h0A0, 9'h1F0},
        {in_fifo1_start, in_fifo2_start, error_fifo_start});
    chk("ends", {9'h04F, 9'h09F, 9'h1EF},
        {in_fifo0_end, in_fifo1_end, in_fifo2_end});
    burst(3'h2, 5'd2, 1'b1);
    chk("pne1", 32'd5, pne_cnt[1]);
    $display("test inbound fifos done");
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_FORCE, 32'h1 << i);
      chk("force", 32'h1 << i, {capture_buffer_nonempty_event,
          partial_nonempty_event, inbound_nonempty_event});
    end
    rd(ADDR_FORCE, 32'h0);
    chk("force_end", 32'h0, {capture_buffer_nonempty_event,
        partial_nonempty_event, inbound_nonempty_event});
    $display("test forced events done");
    wr(ADDR_AUTOSYNC, 32'hFFFF_FFFF);
    rd(ADDR_AUTOSYNC, 32'h7777_773F);
    chk("trk_val", 32'h3_FFFF, out_tracker_start_value);
    wr(ADDR_AUTOSYNC, 32'h0123_4525);
    @(posedge clk);
    #1;
    chk("trk_val", {3'd0, 3'd1, 3'd2, 3'd3, 3'd4, 3'd5},
        out_tracker_start_value);
    chk("trk_en", 32'h25, out_tracker_resync_enable);
    $display("test tracker autosync done");
    wrap_up();
  end
endmodule
`default_nettype wire
